// ### design/hfp_top.sv
/*
 * HDLC frame processor for one serial channel: receive deframer with
 * address filter, CRC check and length check; transmit framer.
 * Assumes line data and strobes are asynchronous pins; strobe rising edge
 * marks one bit, several core clocks per bit. Config inputs are static
 * while frames run.
 */
// How it works
// - Forward matched address bytes first when enabled
// - Masked address bits always count as matching
// - Masks only in recognition modes; zero masks
// - Group address FE/FC ignores the masks
// - I-frame command in auto mode builds address and control itself
// - External CRC: no internal CRC, flag closes
// - Any host frame length is sent unchecked
// - Closing flag opens next waiting frame
// - Receiver accepts shared flags and shared zeros
// - One inserted after seven zeros; zero stuffing
// - Preamble pattern repeats before frame after fill
// - No bit stuffing during preamble
// - CRC-CCITT two bytes or CRC-32 four
// - Last two or four bytes are checksum
// - Forward checksum before status when enabled
// - No checksum: valid-frame minimum length shrinks
// - Maximum length is (blocks+1) times 32
// - Overlong frame ends as abort with status
// - Optional length pulse precedes message-end pulse
// - Discard rest of overlong frame until flag
// - 16-bit high byte: group or two values
// - Mode 1 compares high byte, forwards it when enabled
`timescale 1ns/1ns
`default_nettype none
module hfp_top (
	input  wire logic       CORE_CLK_IN,
	input  wire logic       ARST_N_IN,
	input  wire logic       RX_DATA_IN,
	input  wire logic       RX_STROBE_IN,
	input  wire logic       TX_STROBE_IN,
	output var  logic       TX_DATA_OUT,
	input  wire logic [1:0] MODE_IN,
	input  wire logic       ADDR16_IN,
	input  wire logic       RX_ADDR_FORWARD_EN_IN,
	input  wire logic       RX_CRC_FORWARD_EN_IN,
	input  wire logic       RX_CRC_CHECK_DISABLE_IN,
	input  wire logic       CRC32_SELECT_IN,
	input  wire logic       CMD_RESP_IGNORE_IN,
	input  wire logic [7:0] RX_ADDR_HIGH_A_IN,
	input  wire logic [7:0] RX_ADDR_HIGH_B_IN,
	input  wire logic [7:0] RX_ADDR_LOW_A_IN,
	input  wire logic [7:0] RX_ADDR_LOW_B_IN,
	input  wire logic [7:0] MASK_ADDR_HIGH_A_IN,
	input  wire logic [7:0] MASK_ADDR_HIGH_B_IN,
	input  wire logic [7:0] MASK_ADDR_LOW_A_IN,
	input  wire logic [7:0] MASK_ADDR_LOW_B_IN,
	input  wire logic        RX_LEN_CHECK_EN_IN,
	input  wire logic [10:0] RX_LEN_BLOCKS_IN,
	input  wire logic        FRAME_LEN_EXCEEDED_IRQ_IRQ_EN_IN,
	output var  logic [7:0] RX_DATA_OUT,
	output var  logic       RX_LAST_OUT,
	output var  logic       RX_VALID_OUT,
	input  wire logic       RX_READY_IN,
	output var  logic       RX_MSG_END_IRQ_OUT,
	output var  logic       FRAME_LEN_EXCEEDED_IRQ_OUT,
	input  wire logic       TX_EXTERNAL_CRC_IN,
	input  wire logic       SHARED_FLAG_EN_IN,
	input  wire logic       ONE_INSERTION_EN_IN,
	input  wire logic       PREAMBLE_TX_EN_IN,
	input  wire logic [7:0] PREAMBLE_PATTERN_IN,
	input  wire logic [7:0] PREAMBLE_COUNT_IN,
	input  wire logic       TX_IFRAME_CMD_IN,
	input  wire logic [7:0] TX_ADDR_HIGH_IN,
	input  wire logic [7:0] TX_ADDR_LOW_IN,
	input  wire logic [7:0] TX_CTRL_IN,
	input  wire logic [7:0] TX_DATA_IN,
	input  wire logic       TX_LAST_IN,
	input  wire logic       TX_VALID_IN,
	output var  logic       TX_READY_OUT
);
	hfp_pkg::hfp_state_s s, n;
	hfp_pkg::hfp_rxw_s   rx_w;
	logic                buf_rdy;

	function automatic logic am(input logic [7:0] x, r, m);
		return ((x ^ r) & ~m) == 8'h00;
	endfunction

	function automatic logic hi_ok(input logic [7:0] x, input logic cmd_resp_ignore);
		logic [7:0] cm;
		cm = cmd_resp_ignore ? hfp_pkg::HFP_CR_BIT : 8'h00;
		return ((x | hfp_pkg::HFP_CR_BIT) == hfp_pkg::HFP_GROUP)
			|| am(x, RX_ADDR_HIGH_A_IN, MASK_ADDR_HIGH_A_IN | cm)
			|| am(x, RX_ADDR_HIGH_B_IN, MASK_ADDR_HIGH_B_IN | cm);
	endfunction

	function automatic logic lo_ok(input logic [7:0] x);
		return am(x, RX_ADDR_LOW_A_IN, MASK_ADDR_LOW_A_IN)
			|| am(x, RX_ADDR_LOW_B_IN, MASK_ADDR_LOW_B_IN);
	endfunction

	// Clears per-frame receive fields; line window is kept for shared zeros
	function automatic hfp_pkg::hfp_state_s fresh(input hfp_pkg::hfp_state_s x,
	                                              input logic m0);
		hfp_pkg::hfp_state_s y;
		y = x;
		y.bcnt  = '0;
		y.bitc  = '0;
		y.held  = '0;
		y.eidx  = '0;
		y.dones = '0;
		y.dzer  = '0;
		y.abort = 1'b0;
		y.ovf   = 1'b0;
		y.match = m0;
		y.c16   = hfp_pkg::HFP_C16_INIT;
		y.c32   = hfp_pkg::HFP_C32_INIT;
		y.rx_st = hfp_pkg::RX_FRAME;
		return y;
	endfunction

	always_comb begin
		logic       bi, fl, ab, db, keep, go, upd, tst, crc_ok;
		logic [7:0] b, ob, tb, sh;
		logic [2:0] hn;
		logic [1:0] na, he;
		logic [16:0] maxl;
		bi = 1'b0; fl = 1'b0; ab = 1'b0; db = 1'b0; keep = 1'b0;
		go = 1'b0; upd = 1'b0; tst = 1'b0; crc_ok = 1'b0;
		b = '0; ob = '0; tb = '0; sh = '0; he = '0;
		n = s;
		n.rxd1 = RX_DATA_IN;
		n.rxd2 = s.rxd1;
		n.rxs1 = RX_STROBE_IN;
		n.rxs2 = s.rxs1;
		n.rxs3 = s.rxs2;
		n.txs1 = TX_STROBE_IN;
		n.txs2 = s.txs1;
		n.txs3 = s.txs2;
		n.pv   = 1'b0;
		n.rx_msg_end_irq  = 1'b0;
		n.frame_len_exceeded_irq = 1'b0;
		hn = RX_CRC_CHECK_DISABLE_IN ? 3'h0 : (CRC32_SELECT_IN ? 3'h4 : 3'h2);
		case (MODE_IN)
			hfp_pkg::HFP_AM0: na = 2'h0;
			hfp_pkg::HFP_AM1: na = 2'h1;
			default:          na = ADDR16_IN ? 2'h2 : 2'h1;
		endcase
		maxl = 17'({RX_LEN_BLOCKS_IN, 5'h00}) + hfp_pkg::HFP_LEN_BLK;
		// Lost word when the buffer is full is reported in status
		if (s.pv && !buf_rdy && !s.plast) n.ovf = 1'b1;
		if (s.p2v) begin
			n.pv    = 1'b1;
			n.pd    = s.p2d;
			n.plast = 1'b0;
			n.p2v   = 1'b0;
		end

		// Receive: one line bit per strobe edge
		if (s.rxs2 && !s.rxs3) begin
			bi = s.rxd2;
			n.win = {bi, s.win[7:1]};
			n.rones = bi ? ((s.rones == 3'h7) ? 3'h7 : s.rones + 3'h1) : 3'h0;
			fl = ({bi, s.win[7:1]} == hfp_pkg::HFP_FLAG);
			ab = bi && (s.rones == hfp_pkg::HFP_ABORT_ONES);
			if (fl || ab) n.wcnt = '0;
			else if (s.wcnt != hfp_pkg::HFP_WIN_FULL) n.wcnt = s.wcnt + 4'h1;
			if (ab) begin
				if (s.rx_st == hfp_pkg::RX_FRAME && s.match) begin
					n.abort = 1'b1;
					n.rx_st = hfp_pkg::RX_STAT;
					n.nxt   = hfp_pkg::RX_HUNT;
				end else if (s.rx_st == hfp_pkg::RX_FRAME || s.rx_st == hfp_pkg::RX_DROP) begin
					n.rx_st = hfp_pkg::RX_HUNT;
				end
			end else if (s.wcnt == hfp_pkg::HFP_WIN_FULL && s.rx_st == hfp_pkg::RX_FRAME) begin
				// Last data bit leaves the window on the closing flag's edge
				db = s.win[0];
				if (s.dones == hfp_pkg::HFP_STUFF_ONES && !db) begin
					n.dones = '0;
					n.dzer  = 3'h1;
				end else if (ONE_INSERTION_EN_IN && s.dzer == hfp_pkg::HFP_INS_ZEROS && db) begin
					n.dzer  = '0;
					n.dones = 3'h1;
				end else begin
					keep = 1'b1;
					n.dones = db ? ((s.dones == 3'h7) ? 3'h7 : s.dones + 3'h1) : 3'h0;
					n.dzer  = db ? 3'h0 : ((s.dzer == 3'h7) ? 3'h7 : s.dzer + 3'h1);
				end
			end
		end
		if (keep) begin
			n.sh   = {db, s.sh[7:1]};
			n.bitc = s.bitc + 3'h1;
			if (s.bitc == 3'h7) begin
				b      = {db, s.sh[7:1]};
				n.bcnt = s.bcnt + 17'h1;
				n.c16  = hfp_pkg::crc16(s.c16, b);
				n.c32  = hfp_pkg::crc32(s.c32, b);
				if (RX_LEN_CHECK_EN_IN && n.bcnt > maxl) begin
					n.abort = 1'b1;
					n.frame_len_exceeded_irq  = FRAME_LEN_EXCEEDED_IRQ_IRQ_EN_IN;
					n.nxt   = hfp_pkg::RX_DROP;
					n.rx_st = s.match ? hfp_pkg::RX_STAT : hfp_pkg::RX_DROP;
				end else begin
					n.hist = {s.hist[23:0], b};
					if (s.held < hn) begin
						n.held = s.held + 3'h1;
					end else begin
						ob = (hn == 3'h0) ? b : 8'(s.hist >> {hn - 3'h1, 3'h0});
						if (s.eidx < na) begin
							n.eidx = s.eidx + 2'h1;
							if (s.eidx == 2'h0 && na == 2'h2) begin
								n.hdr = ob;
							end else if (s.eidx == 2'h0) begin
								if (MODE_IN == hfp_pkg::HFP_AM1 ? hi_ok(ob, CMD_RESP_IGNORE_IN)
								                                 : lo_ok(ob)) begin
									n.match = 1'b1;
									n.pv    = RX_ADDR_FORWARD_EN_IN;
									n.pd    = ob;
									n.plast = 1'b0;
								end else begin
									n.rx_st = hfp_pkg::RX_DROP;
								end
							end else if (hi_ok(s.hdr, CMD_RESP_IGNORE_IN) && lo_ok(ob)) begin
								n.match = 1'b1;
								n.pv    = RX_ADDR_FORWARD_EN_IN;
								n.pd    = s.hdr;
								n.plast = 1'b0;
								n.p2v   = RX_ADDR_FORWARD_EN_IN;
								n.p2d   = ob;
							end else begin
								n.rx_st = hfp_pkg::RX_DROP;
							end
						end else begin
							n.pv    = 1'b1;
							n.pd    = ob;
							n.plast = 1'b0;
						end
					end
				end
			end
		end

		// Frame end judged after the last data bit is counted
		if (fl) begin
			case (n.rx_st)
				hfp_pkg::RX_FRAME: begin
					if (n.match && (n.bcnt != '0 || n.bitc != '0)) begin
						n.rx_st = hfp_pkg::RX_FLUSH;
						n.nxt   = hfp_pkg::RX_FRAME;
					end else begin
						n = fresh(n, MODE_IN == hfp_pkg::HFP_AM0);
					end
				end
				hfp_pkg::RX_HUNT, hfp_pkg::RX_DROP: n = fresh(n, MODE_IN == hfp_pkg::HFP_AM0);
				default: ;
			endcase
		end

		// Checksum flush and status byte, one word per core clock
		case (s.rx_st)
			hfp_pkg::RX_FLUSH: begin
				if (RX_CRC_FORWARD_EN_IN && s.held != 3'h0) begin
					n.pv    = 1'b1;
					n.pd    = 8'(s.hist >> {s.held - 3'h1, 3'h0});
					n.plast = 1'b0;
					n.held  = s.held - 3'h1;
				end else begin
					n.rx_st = hfp_pkg::RX_STAT;
				end
			end
			hfp_pkg::RX_STAT: begin
				crc_ok = RX_CRC_CHECK_DISABLE_IN || (CRC32_SELECT_IN ?
					(s.c32 == hfp_pkg::HFP_C32_GOOD) : (s.c16 == hfp_pkg::HFP_C16_GOOD));
				n.pv    = 1'b1;
				n.plast = 1'b1;
				n.rx_msg_end_irq   = 1'b1;
				n.pd    = 8'h00;
				n.pd[hfp_pkg::HFP_ST_VFR] = !s.abort && s.bitc == 3'h0 && crc_ok
					&& s.bcnt > 17'(hn) + 17'(na);
				n.pd[hfp_pkg::HFP_ST_OVF] = s.ovf;
				n.pd[hfp_pkg::HFP_ST_CRC] = crc_ok;
				n.pd[hfp_pkg::HFP_ST_RAB] = s.abort;
				n.rx_st = s.nxt;
				if (s.nxt == hfp_pkg::RX_FRAME) n = fresh(n, MODE_IN == hfp_pkg::HFP_AM0);
			end
			default: ;
		endcase

		// Transmit: one line bit per strobe edge
		if (s.txs2 && !s.txs3) begin
			if (s.tstuff && s.tones == hfp_pkg::HFP_STUFF_ONES) begin
				n.txo   = 1'b0;
				n.tones = '0;
				n.tzer  = (s.tzer == 3'h7) ? 3'h7 : s.tzer + 3'h1;
			end else if (s.tstuff && ONE_INSERTION_EN_IN && s.tzer == hfp_pkg::HFP_INS_ZEROS) begin
				n.txo   = 1'b1;
				n.tzer  = '0;
				n.tones = 3'h1;
			end else begin
				sh  = s.tsh;
				tst = s.tstuff;
				if (s.tbits == 3'h0) begin
					tst = 1'b1;
					case (s.tx_st)
						hfp_pkg::TX_IDLE: begin
							tb  = hfp_pkg::HFP_FLAG;
							tst = 1'b0;
							n.prec = PREAMBLE_COUNT_IN;
							if (s.nbv && PREAMBLE_TX_EN_IN && PREAMBLE_COUNT_IN != 8'h00)
								n.tx_st = hfp_pkg::TX_PRE;
							else go = s.nbv;
						end
						hfp_pkg::TX_PRE: begin
							tb  = PREAMBLE_PATTERN_IN;
							tst = 1'b0;
							n.prec = s.prec - 8'h01;
							if (s.prec == 8'h01) n.tx_st = hfp_pkg::TX_OPEN;
						end
						hfp_pkg::TX_OPEN: begin
							tb  = hfp_pkg::HFP_FLAG;
							tst = 1'b0;
							go  = 1'b1;
						end
						hfp_pkg::TX_HDR: begin
							he  = ADDR16_IN ? s.hidx : s.hidx + 2'h1;
							tb  = (he == 2'h0) ? TX_ADDR_HIGH_IN :
							      (he == 2'h1) ? TX_ADDR_LOW_IN : TX_CTRL_IN;
							upd = 1'b1;
							n.hidx = s.hidx + 2'h1;
							if (he == 2'h2) n.tx_st = hfp_pkg::TX_DATA;
						end
						hfp_pkg::TX_DATA: begin
							if (s.nbv) begin
								tb  = s.nb;
								upd = 1'b1;
								n.nbv = 1'b0;
								n.cidx = '0;
								if (s.nbl) n.tx_st = TX_EXTERNAL_CRC_IN ? hfp_pkg::TX_CLOSE
								                                       : hfp_pkg::TX_CRC;
							end else begin
								// Underrun: ones go out, the far end sees an abort
								tb  = hfp_pkg::HFP_ABORT_FILL;
								tst = 1'b0;
							end
						end
						hfp_pkg::TX_CRC: begin
							tb = ~(CRC32_SELECT_IN ? 8'(s.tc32 >> {s.cidx, 3'h0})
							                       : 8'(s.tc16 >> {s.cidx, 3'h0}));
							n.cidx = s.cidx + 2'h1;
							if (s.cidx == (CRC32_SELECT_IN ? 2'h3 : 2'h1)) n.tx_st = hfp_pkg::TX_CLOSE;
						end
						hfp_pkg::TX_CLOSE: begin
							tb  = hfp_pkg::HFP_FLAG;
							tst = 1'b0;
							if (SHARED_FLAG_EN_IN && s.nbv) go = 1'b1;
							else n.tx_st = hfp_pkg::TX_IDLE;
						end
						default: begin
							tb  = hfp_pkg::HFP_FLAG;
							tst = 1'b0;
							n.tx_st = hfp_pkg::TX_IDLE;
						end
					endcase
					sh = tb;
					if (upd) begin
						n.tc16 = hfp_pkg::crc16(s.tc16, tb);
						n.tc32 = hfp_pkg::crc32(s.tc32, tb);
					end
					if (go) begin
						n.ifr  = TX_IFRAME_CMD_IN && MODE_IN == hfp_pkg::HFP_AUTO;
						n.tc16 = hfp_pkg::HFP_C16_INIT;
						n.tc32 = hfp_pkg::HFP_C32_INIT;
						n.hidx = '0;
						n.tx_st = n.ifr ? hfp_pkg::TX_HDR : hfp_pkg::TX_DATA;
					end
				end
				n.txo    = sh[0];
				n.tsh    = {1'b0, sh[7:1]};
				n.tbits  = s.tbits - 3'h1;
				n.tstuff = tst;
				n.tones  = (tst && sh[0]) ? s.tones + 3'h1 : 3'h0;
				n.tzer   = (tst && !sh[0]) ? s.tzer + 3'h1 : 3'h0;
			end
		end
		if (s.trdy && TX_VALID_IN) begin
			n.nb  = TX_DATA_IN;
			n.nbl = TX_LAST_IN;
			n.nbv = 1'b1;
		end
		n.trdy = !n.nbv;
	end

	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			s     <= '0;
			s.txo <= 1'b1;
		end else begin
			s <= n;
		end
	end

	hfp_buf #(.W(9)) u_rx_buf (
		.clk_in        (CORE_CLK_IN),
		.arst_n_in     (ARST_N_IN),
		.in_data_in    ({s.pd, s.plast}),
		.in_valid_in   (s.pv),
		.in_ready_out  (buf_rdy),
		.out_data_out  (rx_w),
		.out_valid_out (RX_VALID_OUT),
		.out_ready_in  (RX_READY_IN)
	);

	assign RX_DATA_OUT                = rx_w.data;
	assign RX_LAST_OUT                = rx_w.last;
	assign RX_MSG_END_IRQ_OUT         = s.rx_msg_end_irq;
	assign FRAME_LEN_EXCEEDED_IRQ_OUT = s.frame_len_exceeded_irq;
	assign TX_DATA_OUT                = s.txo;
	assign TX_READY_OUT               = s.trdy;

	a_frame_len_exceeded_irq_then_rme: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
		FRAME_LEN_EXCEEDED_IRQ_OUT |=> RX_MSG_END_IRQ_OUT) else $error("length pulse without end");
	a_len_abort_stat: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
		FRAME_LEN_EXCEEDED_IRQ_OUT |=> (s.pv && s.plast && s.pd[hfp_pkg::HFP_ST_RAB]))
		else $error("overlong frame status lacks abort");
	a_len_then_drop: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
		FRAME_LEN_EXCEEDED_IRQ_OUT |=> ##1 (s.rx_st != hfp_pkg::RX_FRAME || s.bcnt == '0))
		else $error("overlong frame not discarded");
	a_crc_hold_max: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
		s.held <= (RX_CRC_CHECK_DISABLE_IN ? 3'h0 : (CRC32_SELECT_IN ? 3'h4 : 3'h2)))
		else $error("too many held checksum bytes");
	a_pre_no_stuff: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
		(s.tx_st == hfp_pkg::TX_OPEN && $past(s.tx_st) == hfp_pkg::TX_PRE) |-> !s.tstuff)
		else $error("stuffing during preamble");
	a_stuff_limit: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
		s.tones <= hfp_pkg::HFP_STUFF_ONES && (!ONE_INSERTION_EN_IN || s.tzer <= 3'h7))
		else $error("ones run not stuffed");
	a_ext_crc_skip: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
		(TX_EXTERNAL_CRC_IN && $past(TX_EXTERNAL_CRC_IN)) |-> s.tx_st != hfp_pkg::TX_CRC)
		else $error("internal CRC with external CRC set");
	a_crc_len: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
		s.tx_st == hfp_pkg::TX_CRC |-> s.cidx <= (CRC32_SELECT_IN ? 2'h3 : 2'h1))
		else $error("wrong checksum length");
	a_status_last: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
		RX_MSG_END_IRQ_OUT |-> (s.pv && s.plast)) else $error("end pulse without status byte");
endmodule // hfp_top
`default_nettype wire

// ### design/hfp_pkg.sv
/*
 * Shared constants, types and CRC helpers for the HDLC frame processor.
 * Assumes one core clock; line bits arrive as data plus strobe pins.
 */
`default_nettype none
package hfp_pkg;
	localparam logic [7:0]  HFP_FLAG       = 8'h7e;
	localparam logic [7:0]  HFP_GROUP      = 8'hfe;
	localparam logic [7:0]  HFP_CR_BIT     = 8'h02;
	localparam logic [7:0]  HFP_ABORT_FILL = 8'hff;
	localparam logic [15:0] HFP_C16_INIT   = 16'hffff;
	localparam logic [15:0] HFP_C16_POLY   = 16'h8408;
	localparam logic [15:0] HFP_C16_GOOD   = 16'hf0b8;
	localparam logic [31:0] HFP_C32_INIT   = 32'hffffffff;
	localparam logic [31:0] HFP_C32_POLY   = 32'hedb88320;
	localparam logic [31:0] HFP_C32_GOOD   = 32'hdebb20e3;
	localparam logic [2:0]  HFP_STUFF_ONES = 3'h5;
	localparam logic [2:0]  HFP_INS_ZEROS  = 3'h7;
	localparam logic [2:0]  HFP_ABORT_ONES = 3'h6;
	localparam logic [3:0]  HFP_WIN_FULL   = 4'h8;
	localparam logic [16:0] HFP_LEN_BLK    = 17'h00020;
	localparam int          HFP_ST_VFR     = 7;
	localparam int          HFP_ST_OVF     = 6;
	localparam int          HFP_ST_CRC     = 5;
	localparam int          HFP_ST_RAB     = 4;

	typedef enum logic [1:0] {
		HFP_AUTO = 2'h0,
		HFP_AM2  = 2'h1,
		HFP_AM1  = 2'h2,
		HFP_AM0  = 2'h3
	} hfp_mode_e;

	typedef enum logic [2:0] {
		RX_HUNT  = 3'h0,
		RX_FRAME = 3'h1,
		RX_DROP  = 3'h2,
		RX_FLUSH = 3'h3,
		RX_STAT  = 3'h4
	} hfp_rx_e;

	typedef enum logic [2:0] {
		TX_IDLE  = 3'h0,
		TX_PRE   = 3'h1,
		TX_OPEN  = 3'h2,
		TX_HDR   = 3'h3,
		TX_DATA  = 3'h4,
		TX_CRC   = 3'h5,
		TX_CLOSE = 3'h6
	} hfp_tx_e;

	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} hfp_rxw_s;

	typedef struct packed {
		logic rxd1, rxd2, rxs1, rxs2, rxs3, txs1, txs2, txs3;
		hfp_rx_e rx_st, nxt;
		logic [7:0] win, sh, hdr, pd, p2d;
		logic [3:0] wcnt;
		logic [2:0] rones, dones, dzer, bitc, held;
		logic [16:0] bcnt;
		logic [31:0] hist, c32;
		logic [15:0] c16;
		logic [1:0] eidx;
		logic match, abort, ovf, pv, plast, p2v, rx_msg_end_irq, frame_len_exceeded_irq;
		hfp_tx_e tx_st;
		logic [7:0] tsh, nb, prec;
		logic [2:0] tbits, tones, tzer;
		logic tstuff, txo, nbl, nbv, trdy, ifr;
		logic [1:0] hidx, cidx;
		logic [15:0] tc16;
		logic [31:0] tc32;
	} hfp_state_s;

	function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ HFP_C16_POLY) : (r >> 1);
		end
		return r;
	endfunction

	function automatic logic [31:0] crc32(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ HFP_C32_POLY) : (r >> 1);
		end
		return r;
	endfunction
endpackage
`default_nettype wire

// ### design/hfp_buf.sv
/*
 * Two-entry skid buffer with valid/ready on both sides.
 * Assumes source and sink share the core clock.
 */
`timescale 1ns/1ns
`default_nettype none
module hfp_buf #(
	parameter int W = 9
) (
	input  wire logic         clk_in,
	input  wire logic         arst_n_in,
	input  wire logic [W-1:0] in_data_in,
	input  wire logic         in_valid_in,
	output var  logic         in_ready_out,
	output var  logic [W-1:0] out_data_out,
	output var  logic         out_valid_out,
	input  wire logic         out_ready_in
);
	typedef struct packed {
		logic [W-1:0] od, sd;
		logic         ov, sv;
	} hfp_bufst_s;
	hfp_bufst_s s, n;

	always_comb begin
		n = s;
		if (!s.ov || out_ready_in) begin
			if (s.sv) begin
				n.od = s.sd;
				n.sv = 1'b0;
				n.ov = 1'b1;
			end else begin
				n.od = in_data_in;
				n.ov = in_valid_in;
			end
		end else if (in_valid_in && !s.sv) begin
			n.sd = in_data_in;
			n.sv = 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) s <= '0;
		else s <= n;
	end

	// Spare slot free means a word is never dropped on a stall
	assign in_ready_out  = !s.sv;
	assign out_data_out  = s.od;
	assign out_valid_out = s.ov;
endmodule // hfp_buf
`default_nettype wire

// ### test/hfp_remote.sv
/* Remote station model: sends stuffed frames on the receive line and
   decodes the transmit line. Assumes one core clock and the bench tasks. */
`timescale 1ns/1ns
`default_nettype none
module hfp_remote (
	input  wire logic clk_in,
	output var  logic rx_data_out,
	output var  logic rx_strobe_out,
	output var  logic tx_strobe_out,
	input  wire logic tx_data_in
);
	int         rk, ones, n;
	logic [7:0] sh, cur;
	logic [7:0] part[$], got[$];
	initial begin
		rx_data_out = 1'b1;
		rx_strobe_out = 1'b0;
		tx_strobe_out = 1'b0;
		// Transmit clock runs free, idle flags fill gaps
		forever begin
			repeat (3) @(posedge clk_in);
			#1 tx_strobe_out = ~tx_strobe_out;
		end
	end
	task automatic put_bit(input logic b);
		@(posedge clk_in);
		#1 rx_data_out = b;
		rx_strobe_out = 1'b0;
		repeat (3) @(posedge clk_in);
		#1 rx_strobe_out = 1'b1;
		repeat (2) @(posedge clk_in);
	endtask
	task automatic put_byte(input logic [7:0] v, input logic stuff);
		for (int i = 0; i < 8; i++) begin
			put_bit(v[i]);
			rk = v[i] ? rk + 1 : 0;
			if (stuff && rk == 5) begin
				put_bit(1'b0);
				rk = 0;
			end
		end
	endtask
	task automatic send_frame(input logic [7:0] q[$]);
		put_byte(hfp_pkg::HFP_FLAG, 1'b0);
		foreach (q[i]) put_byte(q[i], 1'b1);
		put_byte(hfp_pkg::HFP_FLAG, 1'b0);
		@(posedge clk_in);
		// Released line must not keep showing the last bit
		#1 rx_data_out = ~rx_data_out;
		rx_strobe_out = 1'b0;
	endtask
	// Frames appended to one queue; preamble shows as a frame of its own
	always @(posedge tx_strobe_out) begin
		sh = {tx_data_in, sh[7:1]};
		if (sh == hfp_pkg::HFP_FLAG) begin
			got = {got, part};
			part.delete();
			n = 0;
			ones = 0;
		end else if (ones == 5 && tx_data_in == 1'b0) begin
			ones = 0;
		end else begin
			ones = tx_data_in ? ones + 1 : 0;
			cur = {tx_data_in, cur[7:1]};
			n++;
			if (n == 8) begin
				part.push_back(cur);
				n = 0;
			end
		end
	end
endmodule // hfp_remote
`default_nettype wire

// ### test/hfp_top_tb_top.sv
/* Bench for the frame processor: frames pass the remote model, receive
   words are collected at the buffer output. Assumes hfp_remote. */
`timescale 1ns/1ns
`default_nettype none
module hfp_top_tb_top;
	logic        CORE_CLK_IN, ARST_N_IN, RX_DATA_IN, RX_STROBE_IN, TX_STROBE_IN, TX_DATA_OUT;
	logic        ADDR16_IN, RX_ADDR_FORWARD_EN_IN, RX_CRC_FORWARD_EN_IN, RX_CRC_CHECK_DISABLE_IN;
	logic        CRC32_SELECT_IN, CMD_RESP_IGNORE_IN, RX_LEN_CHECK_EN_IN, FRAME_LEN_EXCEEDED_IRQ_IRQ_EN_IN;
	logic        RX_LAST_OUT, RX_VALID_OUT, RX_READY_IN, RX_MSG_END_IRQ_OUT, TX_LAST_IN;
	logic        FRAME_LEN_EXCEEDED_IRQ_OUT, TX_EXTERNAL_CRC_IN, SHARED_FLAG_EN_IN;
	logic        ONE_INSERTION_EN_IN, PREAMBLE_TX_EN_IN, TX_IFRAME_CMD_IN;
	logic        TX_VALID_IN, TX_READY_OUT, frame_len_exceeded_irq_q, frame_len_exceeded_irq_rme;
	logic [1:0]  MODE_IN;
	logic [10:0] RX_LEN_BLOCKS_IN;
	logic [7:0]  RX_ADDR_HIGH_A_IN, RX_ADDR_HIGH_B_IN, RX_ADDR_LOW_A_IN, RX_ADDR_LOW_B_IN;
	logic [7:0]  MASK_ADDR_HIGH_A_IN, MASK_ADDR_HIGH_B_IN, MASK_ADDR_LOW_A_IN;
	logic [7:0]  MASK_ADDR_LOW_B_IN, RX_DATA_OUT, PREAMBLE_PATTERN_IN, PREAMBLE_COUNT_IN;
	logic [7:0]  TX_ADDR_HIGH_IN, TX_ADDR_LOW_IN, TX_CTRL_IN, TX_DATA_IN;
	logic [7:0]  fr[$], tq[$];
	logic [8:0]  rxq[$], ex[$];
	int          failures, samples_checked;
	hfp_top dut (.*);
	hfp_remote u_rem (
		.clk_in       (CORE_CLK_IN),
		.rx_data_out  (RX_DATA_IN),
		.rx_strobe_out(RX_STROBE_IN),
		.tx_strobe_out(TX_STROBE_IN),
		.tx_data_in   (TX_DATA_OUT)
	);
	initial begin
		CORE_CLK_IN = 1'b0;
		forever #5 CORE_CLK_IN = ~CORE_CLK_IN;
	end
	always @(posedge CORE_CLK_IN) begin
		if (RX_VALID_OUT === 1'b1 && RX_READY_IN === 1'b1) rxq.push_back({RX_LAST_OUT, RX_DATA_OUT});
		if (RX_MSG_END_IRQ_OUT === 1'b1 && frame_len_exceeded_irq_q === 1'b1) frame_len_exceeded_irq_rme = 1'b1;
		frame_len_exceeded_irq_q = FRAME_LEN_EXCEEDED_IRQ_OUT;
	end
	task automatic check(input logic [8:0] got, input logic [8:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic add_fcs(ref logic [7:0] q[$], input bit c32);
		logic [31:0] r;
		logic [31:0] p;
		r = c32 ? 32'hffffffff : 32'h0000ffff;
		p = c32 ? hfp_pkg::HFP_C32_POLY : {16'h0000, hfp_pkg::HFP_C16_POLY};
		foreach (q[i])
			for (int j = 0; j < 8; j++)
				r = (r[0] ^ q[i][j]) ? (r >> 1) ^ p : r >> 1;
		// Check sequence goes out inverted, low byte first
		for (int i = 0; i < (c32 ? 4 : 2); i++) q.push_back(~r[8*i+:8]);
	endtask
	task automatic rx_case(input logic [8:0] ms);
		rxq.delete();
		u_rem.send_frame(fr);
		for (int k = 0; k < 300 && !(rxq.size() > 0 && rxq[$][8]); k++) @(posedge CORE_CLK_IN);
		check(9'(rxq.size()), 9'(ex.size()));
		foreach (ex[i]) check(rxq[i] & (i == ex.size() - 1 ? ms : 9'h1ff), ex[i]);
		#1;
	endtask
	task automatic rx_basic();
		fr = '{8'h11, 8'h22, 8'h33};
		add_fcs(fr, 1'b0);
		ex = '{9'h011, 9'h022, 9'h033, 9'h1a0};
		rx_case(9'h1ff);
	endtask
	task automatic tx_case();
		u_rem.got.delete();
		@(posedge CORE_CLK_IN);
		foreach (tq[i]) begin
			#1 TX_DATA_IN = tq[i];
			TX_LAST_IN = (i == tq.size() - 1);
			TX_VALID_IN = 1'b1;
			do @(posedge CORE_CLK_IN); while (TX_READY_OUT !== 1'b1);
		end
		#1 TX_VALID_IN = 1'b0;
		for (int k = 0; k < 3000 && u_rem.got.size() < fr.size(); k++) @(posedge CORE_CLK_IN);
		check(9'(u_rem.got.size()), 9'(fr.size()));
		foreach (fr[i]) check({1'b0, u_rem.got[i]}, {1'b0, fr[i]});
		#1;
	endtask
	task automatic complete_run();
		if (failures == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Whole run needs roughly six thousand cycles
	initial begin
		#500000;
		failures++;
		complete_run();
	end
	initial begin
		ARST_N_IN = 1'b0;
		RX_READY_IN = 1'b1;
		{MODE_IN, ADDR16_IN, RX_ADDR_FORWARD_EN_IN, RX_CRC_FORWARD_EN_IN, RX_CRC_CHECK_DISABLE_IN,
			CRC32_SELECT_IN, CMD_RESP_IGNORE_IN, RX_LEN_CHECK_EN_IN, RX_LEN_BLOCKS_IN} = '0;
		{RX_ADDR_HIGH_A_IN, RX_ADDR_HIGH_B_IN, RX_ADDR_LOW_A_IN, RX_ADDR_LOW_B_IN} = '0;
		{MASK_ADDR_HIGH_A_IN, MASK_ADDR_HIGH_B_IN, MASK_ADDR_LOW_A_IN, MASK_ADDR_LOW_B_IN} = '0;
		{FRAME_LEN_EXCEEDED_IRQ_IRQ_EN_IN, TX_EXTERNAL_CRC_IN, ONE_INSERTION_EN_IN, PREAMBLE_TX_EN_IN} = '0;
		{PREAMBLE_PATTERN_IN, PREAMBLE_COUNT_IN, TX_IFRAME_CMD_IN, TX_ADDR_HIGH_IN} = '0;
		{TX_ADDR_LOW_IN, TX_CTRL_IN, TX_DATA_IN, TX_LAST_IN, TX_VALID_IN} = '0;
		SHARED_FLAG_EN_IN = 1'b1;
		repeat (2) @(posedge CORE_CLK_IN);
		#1 ARST_N_IN = 1'b1;
		repeat (2) @(posedge CORE_CLK_IN);
		#1 MODE_IN = hfp_pkg::HFP_AM0;
		rx_basic();
		MODE_IN = hfp_pkg::HFP_AM1;
		{RX_ADDR_HIGH_A_IN, MASK_ADDR_HIGH_A_IN} = {8'h40, 8'h0f};
		{RX_ADDR_FORWARD_EN_IN, RX_CRC_FORWARD_EN_IN, CRC32_SELECT_IN} = 3'h7;
		fr = '{8'h4a, 8'h03, 8'h99};
		add_fcs(fr, 1'b1);
		ex = '{9'h04a, 9'h003, 9'h099};
		for (int i = 3; i < 7; i++) ex.push_back({1'b0, fr[i]});
		ex.push_back(9'h1a0);
		rx_case(9'h1ff);
		MASK_ADDR_HIGH_A_IN = 8'h00;
		fr = '{8'h4a, 8'h03};
		add_fcs(fr, 1'b1);
		ex = {};
		rx_case(9'h1ff);
		{MASK_ADDR_HIGH_A_IN, CMD_RESP_IGNORE_IN, RX_ADDR_FORWARD_EN_IN, RX_CRC_FORWARD_EN_IN} = 11'h00c;
		fr = '{8'hfc, 8'h03};
		add_fcs(fr, 1'b1);
		ex = '{9'h003, 9'h1a0};
		rx_case(9'h1ff);
		{MODE_IN, CRC32_SELECT_IN, RX_CRC_CHECK_DISABLE_IN} = {hfp_pkg::HFP_AM0, 2'h1};
		fr = '{8'h11, 8'h22, 8'h33};
		ex = '{9'h011, 9'h022, 9'h033, 9'h180};
		rx_case(9'h180);
		{RX_CRC_CHECK_DISABLE_IN, RX_LEN_CHECK_EN_IN, FRAME_LEN_EXCEEDED_IRQ_IRQ_EN_IN} = 3'h3;
		frame_len_exceeded_irq_rme = 1'b0;
		fr.delete();
		repeat (40) fr.push_back(8'h5a);
		add_fcs(fr, 1'b0);
		rxq.delete();
		u_rem.send_frame(fr);
		repeat (100) @(posedge CORE_CLK_IN);
		check(rxq[$] & 9'h110, 9'h110);
		check({8'h00, frame_len_exceeded_irq_rme}, 9'h001);
		#1 rx_basic();
		{PREAMBLE_TX_EN_IN, PREAMBLE_PATTERN_IN, PREAMBLE_COUNT_IN} = {1'b1, 8'h55, 8'h02};
		tq = '{8'h01, 8'h03, 8'hc5};
		fr = tq;
		add_fcs(fr, 1'b0);
		fr = {8'h55, 8'h55, fr};
		tx_case();
		{PREAMBLE_TX_EN_IN, TX_EXTERNAL_CRC_IN} = 2'h1;
		tq = '{8'h7e};
		fr = tq;
		tx_case();
		{TX_EXTERNAL_CRC_IN, MODE_IN, TX_IFRAME_CMD_IN, ADDR16_IN} = {1'b0, hfp_pkg::HFP_AUTO, 2'h3};
		{TX_ADDR_HIGH_IN, TX_ADDR_LOW_IN, TX_CTRL_IN} = 24'h021120;
		tq = '{8'haa};
		fr = '{8'h02, 8'h11, 8'h20, 8'haa};
		add_fcs(fr, 1'b0);
		tx_case();
		{RX_ADDR_HIGH_B_IN, RX_ADDR_LOW_B_IN, RX_ADDR_FORWARD_EN_IN} = {16'h1234, 1'b1};
		fr = '{8'h12, 8'h34, 8'h77};
		add_fcs(fr, 1'b0);
		ex = '{9'h012, 9'h034, 9'h077, 9'h1a0};
		rx_case(9'h1ff);
		complete_run();
	end
endmodule // hfp_top_tb_top
`default_nettype wire
